/* File: src/oag_addr_gen.sv */
`timescale 1ns/1ns
module oag_addr_gen
  import oag_pkg::*;
(
  // clock, reset, enable
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              ce,
  // request from decode
  input  wire logic              start,
  input  wire logic [2:0]        mode,
  input  wire logic [BYTE_W-1:0] indexIn,
  // operand byte stream from fetch unit
  output logic                   fetchReq_r,
  input  wire logic              fetchValid,
  input  wire logic [BYTE_W-1:0] fetchData,
  // data memory read port
  output logic                   memRd_r,
  output logic [ADDR_W-1:0]      memAddr_r,
  input  wire logic              memValid,
  input  wire logic [BYTE_W-1:0] memData,
  // result
  output logic                   busy_r,
  output logic                   eaValid_r,
  output logic [ADDR_W-1:0]      ea_r
);
  oag_state_t             state_r;
  logic [2:0]             mode_r;
  logic [BYTE_W-1:0]      idx_r;
  logic [BYTE_W-1:0]      offHi_r;
  logic [BYTE_W-1:0]      offLo_r;
  logic [BYTE_W-1:0]      ptrHi_r;
  logic [BYTE_W-1:0]      ptrLo_r;
  logic [1:0]             fetchCnt_r;

  wire logic              accept;
  wire logic              byteIn;
  wire logic              memIn;
  wire logic              newLong;
  wire logic              newNone;
  wire logic              curInd;
  wire logic              curIndLong;
  wire logic              curIdx;
  wire logic [ADDR_W-1:0] ptrLoc;
  wire logic [ADDR_W-1:0] base;
  wire logic [ADDR_W-1:0] sum;

  assign accept     = ce && start && (state_r == ST_IDLE);
  assign byteIn     = ce && fetchReq_r && fetchValid;
  assign memIn      = ce && memRd_r && memValid;
  assign newLong    = (mode == MODE_DIR_LONG) || (mode == MODE_IDX_LONG);
  assign newNone    = (mode == MODE_IDX_NONE);
  assign curInd     = (mode_r == MODE_IND_SHORT) || (mode_r == MODE_IND_LONG);
  assign curIndLong = (mode_r == MODE_IND_LONG);
  assign curIdx     = (mode_r == MODE_IDX_NONE) || (mode_r == MODE_IDX_SHORT)
                   || (mode_r == MODE_IDX_LONG);
  // pointers start in page zero, addressed by the single byte after the opcode
  assign ptrLoc     = {BYTE_ZERO, offLo_r};
  // high bytes are cleared at accept, so short forms fall out of the same adder
  assign base       = curInd ? {ptrHi_r, ptrLo_r} : {offHi_r, offLo_r};

  oag_ea_adder u_adder (
    .base     (base),
    .index    (idx_r),
    .useIndex (curIdx),
    .sum      (sum)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r    <= ST_IDLE;
      mode_r     <= MODE_DIR_SHORT;
      idx_r      <= BYTE_ZERO;
      offHi_r    <= BYTE_ZERO;
      offLo_r    <= BYTE_ZERO;
      ptrHi_r    <= BYTE_ZERO;
      ptrLo_r    <= BYTE_ZERO;
      fetchCnt_r <= CNT_ZERO;
      fetchReq_r <= 1'b0;
      memRd_r    <= 1'b0;
      memAddr_r  <= ADDR_ZERO;
      busy_r     <= 1'b0;
      eaValid_r  <= 1'b0;
      ea_r       <= ADDR_ZERO;
    end else if (ce) begin
      eaValid_r <= 1'b0;
      unique case (state_r)
        ST_IDLE: begin
          if (start) begin
            mode_r     <= mode;
            idx_r      <= indexIn;
            offHi_r    <= BYTE_ZERO;
            offLo_r    <= BYTE_ZERO;
            ptrHi_r    <= BYTE_ZERO;
            ptrLo_r    <= BYTE_ZERO;
            fetchCnt_r <= CNT_ZERO;
            busy_r     <= 1'b1;
            fetchReq_r <= !newNone;
            if (newNone) begin
              state_r <= ST_DONE;
            end else if (newLong) begin
              state_r <= ST_OP_HI;
            end else begin
              state_r <= ST_OP_LO;
            end
          end
        end
        ST_OP_HI: begin
          if (fetchValid) begin
            offHi_r    <= fetchData;
            fetchCnt_r <= fetchCnt_r + CNT_ONE;
            state_r    <= ST_OP_LO;
          end
        end
        ST_OP_LO: begin
          if (fetchValid) begin
            offLo_r    <= fetchData;
            fetchCnt_r <= fetchCnt_r + CNT_ONE;
            fetchReq_r <= 1'b0;
            if (curIndLong) begin
              memRd_r   <= 1'b1;
              memAddr_r <= {BYTE_ZERO, fetchData};
              state_r   <= ST_PTR_HI;
            end else if (curInd) begin
              memRd_r   <= 1'b1;
              memAddr_r <= {BYTE_ZERO, fetchData};
              state_r   <= ST_PTR_LO;
            end else begin
              state_r <= ST_DONE;
            end
          end
        end
        ST_PTR_HI: begin
          if (memValid) begin
            ptrHi_r   <= memData;
            memAddr_r <= ptrLoc + ADDR_STEP;
            state_r   <= ST_PTR_LO;
          end
        end
        ST_PTR_LO: begin
          if (memValid) begin
            ptrLo_r <= memData;
            memRd_r <= 1'b0;
            state_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          ea_r      <= sum;
          eaValid_r <= 1'b1;
          busy_r    <= 1'b0;
          state_r   <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // expected operand bytes per mode, checked at the result
  wire logic [1:0] expCnt;
  assign expCnt = (mode_r == MODE_IDX_NONE) ? CNT_ZERO
                : ((mode_r == MODE_DIR_LONG) || (mode_r == MODE_IDX_LONG)) ? CNT_TWO
                : CNT_ONE;

  // the done step only runs on an enabled edge, so the antecedent requires the edge right after accept to be enabled
  sequence s_accept_none;
    accept && newNone ##1 ce;
  endsequence

  sequence s_result_none;
    !fetchReq_r ##1 eaValid_r;
  endsequence

  property p_idx_none;
    @(posedge mclk) disable iff (rst)
    s_accept_none |-> s_result_none ##0 (ea_r == {BYTE_ZERO, $past(indexIn, 2)});
  endproperty
  a_idx_none: assert property (p_idx_none) else $error("no-offset address wrong");

  property p_byte_count;
    @(posedge mclk) disable iff (rst)
    eaValid_r |-> fetchCnt_r == expCnt;
  endproperty
  a_byte_count: assert property (p_byte_count) else $error("operand byte count wrong");

  property p_idx_short;
    @(posedge mclk) disable iff (rst)
    eaValid_r && mode_r == MODE_IDX_SHORT
      |-> ea_r == {BYTE_ZERO, offLo_r} + {BYTE_ZERO, idx_r} && ea_r <= IDX_SHORT_MAX;
  endproperty
  a_idx_short: assert property (p_idx_short) else $error("short indexed address wrong");

  property p_idx_long;
    @(posedge mclk) disable iff (rst)
    eaValid_r && mode_r == MODE_IDX_LONG
      |-> ea_r == ADDR_W'({offHi_r, offLo_r} + {BYTE_ZERO, idx_r});
  endproperty
  a_idx_long: assert property (p_idx_long) else $error("long indexed address wrong");

  property p_dir;
    @(posedge mclk) disable iff (rst)
    eaValid_r && (mode_r == MODE_DIR_SHORT || mode_r == MODE_DIR_LONG)
      |-> ea_r == {offHi_r, offLo_r};
  endproperty
  a_dir: assert property (p_dir) else $error("direct address wrong");

  property p_ind_short;
    @(posedge mclk) disable iff (rst)
    eaValid_r && mode_r == MODE_IND_SHORT |-> ea_r == {BYTE_ZERO, ptrLo_r};
  endproperty
  a_ind_short: assert property (p_ind_short) else $error("short indirect wrong");

  sequence s_ptr_hi_read;
    memIn && state_r == ST_PTR_HI;
  endsequence

  property p_ind_long_order;
    @(posedge mclk) disable iff (rst)
    s_ptr_hi_read |=> memRd_r && memAddr_r == $past(memAddr_r) + ADDR_STEP
      && ptrHi_r == $past(memData);
  endproperty
  a_ind_long_order: assert property (p_ind_long_order) else $error("pointer order wrong");

  property p_ind_long;
    @(posedge mclk) disable iff (rst)
    eaValid_r && mode_r == MODE_IND_LONG |-> ea_r == {ptrHi_r, ptrLo_r};
  endproperty
  a_ind_long: assert property (p_ind_long) else $error("long indirect wrong");

  property p_ptr_page0;
    @(posedge mclk) disable iff (rst)
    byteIn && state_r == ST_OP_LO && curInd
      |=> memRd_r && memAddr_r == {BYTE_ZERO, $past(fetchData)};
  endproperty
  a_ptr_page0: assert property (p_ptr_page0) else $error("pointer location wrong");
endmodule : oag_addr_gen

/* File: src/oag_ea_adder.sv */
`timescale 1ns/1ns
package oag_pkg;
  // operand addressing mode codes presented with each request
  localparam logic [2:0] MODE_DIR_SHORT = 3'h0;
  localparam logic [2:0] MODE_DIR_LONG  = 3'h1;
  localparam logic [2:0] MODE_IDX_NONE  = 3'h2;
  localparam logic [2:0] MODE_IDX_SHORT = 3'h3;
  localparam logic [2:0] MODE_IDX_LONG  = 3'h4;
  localparam logic [2:0] MODE_IND_SHORT = 3'h5;
  localparam logic [2:0] MODE_IND_LONG  = 3'h6;
  // field layout and fixed values
  localparam int          BYTE_W       = 8;
  localparam int          ADDR_W       = 16;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [15:0] ADDR_ZERO    = 16'h0000;
  localparam logic [15:0] ADDR_STEP    = 16'h0001;
  localparam logic [15:0] IDX_SHORT_MAX = 16'h01FE;
  localparam logic [1:0]  CNT_ZERO     = 2'h0;
  localparam logic [1:0]  CNT_ONE      = 2'h1;
  localparam logic [1:0]  CNT_TWO      = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE, ST_OP_HI, ST_OP_LO, ST_PTR_HI, ST_PTR_LO, ST_DONE
  } oag_state_t;
endpackage : oag_pkg

module oag_ea_adder
  import oag_pkg::*;
(
  // operands
  input  wire logic [ADDR_W-1:0] base,
  input  wire logic [BYTE_W-1:0] index,
  input  wire logic              useIndex,
  // result
  output wire logic [ADDR_W-1:0] sum
);
  wire logic [ADDR_W-1:0] idxExt;

  // unsigned: index is zero-extended, sum wraps in the 64 Kbyte space
  assign idxExt = useIndex ? {BYTE_ZERO, index} : ADDR_ZERO;
  assign sum    = base + idxExt;
endmodule : oag_ea_adder

/* File: testbench/oag_far_model.sv */
`timescale 1ns/1ns
module oag_far_model (
  // clock and pacing
  input  wire logic        mclk,
  input  wire logic        ce,
  input  wire logic [1:0]  stall,
  // operand byte stream
  input  wire logic        fetchReq,
  output logic             fetchValid,
  output logic [7:0]       fetchData,
  // data memory
  input  wire logic        memRd,
  input  wire logic [15:0] memAddr,
  output logic             memValid,
  output logic [7:0]       memData
);
  logic [7:0] opQ[$];
  logic [7:0] mem[int];
  int         nFetch;
  int         nRead;

  initial begin
    fetchValid = 1'b0;
    fetchData  = 8'h00;
    memValid   = 1'b0;
    memData    = 8'h00;
    nFetch     = 0;
    nRead      = 0;
  end

  // idle lines show the inverse so a stale byte never looks right
  always @(negedge mclk) begin
    fetchValid = fetchReq && !stall[0] && opQ.size() > 0;
    fetchData  = fetchValid ? opQ[0] : ~fetchData;
    memValid   = memRd && !stall[1];
    memData    = (memValid && mem.exists(memAddr)) ? mem[memAddr] : ~memData;
  end

  always @(posedge mclk) begin
    if (ce && fetchReq && fetchValid) begin
      void'(opQ.pop_front());
      nFetch++;
    end
    if (ce && memRd && memValid) begin
      nRead++;
    end
  end
endmodule : oag_far_model

/* File: testbench/operand_address_generator_tb.sv */
`timescale 1ns/1ns
module operand_address_generator_tb;
  import oag_pkg::*;
  logic        mclk, rst, ce, start, slow;
  logic [2:0]  mode;
  logic [7:0]  indexIn;
  logic [1:0]  stall;
  logic        fetchReq, fetchValid, memRd, memValid, busy, eaValid;
  logic [7:0]  fetchData, memData;
  logic [15:0] memAddr, ea;
  int          n_fail, check_count, seed;

  oag_addr_gen u_oag_addr_gen (.mclk(mclk), .rst(rst), .ce(ce), .start(start), .mode(mode),
    .indexIn(indexIn), .fetchReq_r(fetchReq), .fetchValid(fetchValid),
    .fetchData(fetchData), .memRd_r(memRd), .memAddr_r(memAddr), .memValid(memValid),
    .memData(memData), .busy_r(busy), .eaValid_r(eaValid), .ea_r(ea));
  oag_far_model u_far (.mclk(mclk), .ce(ce), .stall(stall), .fetchReq(fetchReq),
    .fetchValid(fetchValid), .fetchData(fetchData), .memRd(memRd), .memAddr(memAddr),
    .memValid(memValid), .memData(memData));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // slow runs freeze the core and stall both far-side answers at random
  always @(negedge mclk) begin
    ce    <= !slow || $random(seed) % 2 == 0;
    stall <= slow ? 2'($random(seed)) : 2'h0;
  end

  task check(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task conclude;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  task run(input logic [2:0] m, input logic [7:0] x, b0, b1, p0, p1);
    int          t, nf, nm;
    logic [15:0] exp, loc;
    loc = {8'h00, b0};
    u_far.opQ = {b0, b1};
    u_far.nFetch = 0;
    u_far.nRead = 0;
    u_far.mem.delete();
    u_far.mem[loc] = p0;
    u_far.mem[loc + 16'h0001] = p1;
    case (m)
      MODE_DIR_SHORT: begin exp = {8'h00, b0}; nf = 1; nm = 0; end
      MODE_DIR_LONG:  begin exp = {b0, b1}; nf = 2; nm = 0; end
      MODE_IDX_NONE:  begin exp = {8'h00, x}; nf = 0; nm = 0; end
      MODE_IDX_SHORT: begin exp = {8'h00, b0} + {8'h00, x}; nf = 1; nm = 0; end
      MODE_IDX_LONG:  begin exp = {b0, b1} + {8'h00, x}; nf = 2; nm = 0; end
      MODE_IND_SHORT: begin exp = {8'h00, p0}; nf = 1; nm = 1; end
      MODE_IND_LONG:  begin exp = {p0, p1}; nf = 1; nm = 2; end
      default:        begin exp = {8'h00, b0}; nf = 1; nm = 0; end
    endcase
    start <= 1'b1;
    mode <= m;
    indexIn <= x;
    t = 0;
    do begin @(negedge mclk); t++; end while (busy !== 1'b1 && t < 100);
    // scramble request fields once taken, they must already be latched
    start <= 1'b0;
    mode <= 3'($random(seed));
    indexIn <= 8'($random(seed));
    while (eaValid !== 1'b1 && t < 300) begin @(negedge mclk); t++; end
    if (eaValid !== 1'b1) begin
      n_fail++;
      $display("ERROR %0t no result for mode %0d", $time, m);
      conclude();
    end
    check(ea, exp, "address");
    check(16'(u_far.nFetch), 16'(nf), "operand bytes");
    check(16'(u_far.nRead), 16'(nm), "pointer reads");
    $display("test mode %0d slow %0d done", m, slow);
  endtask : run

  initial begin
    seed = 32'h6685_3991;
    rst = 1'b1;
    ce = 1'b1;
    stall = 2'h0;
    slow = 1'b0;
    start = 1'b0;
    mode = 3'h0;
    indexIn = 8'h00;
    n_fail = 0;
    check_count = 0;
    repeat (2) @(negedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    run(MODE_IDX_SHORT, 8'hFF, 8'hFF, 8'h12, 8'h34, 8'h56);
    run(MODE_IDX_LONG, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00);
    run(MODE_IDX_NONE, 8'hFF, 8'h9A, 8'hBC, 8'h00, 8'h00);
    run(MODE_IND_LONG, 8'h00, 8'hFF, 8'h00, 8'hA5, 8'h3C);
    // reset in the middle of a pointer read must drop every request and the result
    start <= 1'b1;
    mode <= MODE_IND_LONG;
    repeat (3) @(negedge mclk);
    rst <= 1'b1;
    start <= 1'b0;
    repeat (2) @(negedge mclk);
    check({12'h000, fetchReq, memRd, busy, eaValid}, 16'h0000, "reset flags");
    check(ea, 16'h0000, "reset address");
    $display("test reset in mid-transfer done");
    rst <= 1'b0;
    @(negedge mclk);
    for (int pass = 0; pass < 2; pass++) begin
      slow = pass[0];
      for (int i = 0; i < 32; i++) begin
        run(3'(i % 8), 8'($random(seed)), 8'($random(seed)), 8'($random(seed)),
            8'($random(seed)), 8'($random(seed)));
      end
    end
    conclude();
  end
endmodule : operand_address_generator_tb
